// [include/rtcc_pkg.sv]
package rtcc_pkg;

    // Register offsets
    localparam logic [7:0] RTCC_OFS_RATE_BANK = 8'h0A;
    localparam logic [7:0] RTCC_OFS_MODE      = 8'h0B;
    localparam logic [7:0] RTCC_OFS_FLAGS     = 8'h0C;
    localparam logic [7:0] RTCC_OFS_VALIDITY  = 8'h0D;

    // Field positions
    localparam int RTCC_RATE_LSB    = 0;
    localparam int RTCC_BANK_LSB    = 4;
    localparam int RTCC_UIP_BIT     = 7;
    localparam int RTCC_DST_BIT     = 0;
    localparam int RTCC_H24_BIT     = 1;
    localparam int RTCC_BIN_BIT     = 2;
    localparam int RTCC_UIE_BIT     = 4;
    localparam int RTCC_AIE_BIT     = 5;
    localparam int RTCC_PIE_BIT     = 6;
    localparam int RTCC_FREEZE_BIT  = 7;
    localparam int RTCC_UF_BIT      = 4;
    localparam int RTCC_AF_BIT      = 5;
    localparam int RTCC_PF_BIT      = 6;
    localparam int RTCC_IRQ_PENDING_SUMMARY_BIT    = 7;
    localparam int RTCC_VALID_BIT   = 7;

    // Divider chain timing, counted in oscillator ticks
    localparam longint RTCC_OSC_HZ         = 32768;
    localparam longint RTCC_NS_PER_S       = 1000000000;
    localparam longint RTCC_UIP_LEAD_NS    = 244000;
    localparam longint RTCC_ALARM_DELAY_NS = 30500;
    localparam int RTCC_UIP_LEAD_TICKS =
        int'((RTCC_UIP_LEAD_NS * RTCC_OSC_HZ + RTCC_NS_PER_S - 1) / RTCC_NS_PER_S);
    localparam int RTCC_ALARM_DELAY_TICKS =
        int'((RTCC_ALARM_DELAY_NS * RTCC_OSC_HZ + RTCC_NS_PER_S - 1) / RTCC_NS_PER_S);
    localparam logic [14:0] RTCC_UPD_POS = 15'(RTCC_UIP_LEAD_TICKS);

    // Divider chain control codes
    localparam logic [2:0] RTCC_DV_BANK0 = 3'h2;
    localparam logic [2:0] RTCC_DV_BANK1 = 3'h3;
    localparam logic [2:0] RTCC_DV_BANK2 = 3'h4;
    localparam logic [2:0] RTCC_DV_TEST  = 3'h5;

    typedef enum logic [3:0] {
        RTCC_DIV_RUN   = 4'h1,
        RTCC_DIV_HALT  = 4'h2,
        RTCC_DIV_RESET = 4'h4,
        RTCC_DIV_TEST  = 4'h8
    } rtcc_div_mode_t;

    typedef struct packed {
        logic [2:0]  sync_osc;
        logic [1:0]  sync_low;
        logic [14:0] div_cnt;
        logic [3:0]  tick_rate_select;
        logic [2:0]  divider_bank_ctrl;
        logic        dst_enable;
        logic        hour24_sel;
        logic        binary_format_sel;
        logic        freeze;
        logic        update_irq_en;
        logic        alarm_irq_en;
        logic        periodic_irq_en;
        logic        update_done_flag;
        logic        alarm_hit_flag;
        logic        periodic_tick_flag;
        logic [1:0]  alarm_delay;
        logic        supply_valid;
        logic        wr_unlock;
        logic        irq;
        logic        upd_pulse;
        logic [7:0]  rdata;
    } rtcc_state_t;

    localparam rtcc_state_t RTCC_POR_STATE = '0;

endpackage : rtcc_pkg

// [logic/rtcc_ctrl_regs.sv]
// Notes on behaviour
// R1 - Register writes are ignored until software has read the supply validity register.
// R2 - Rate select picks one of thirteen divider taps; zero disables periodic ticks.
// R3 - Rate select and divider control survive master reset and are read/write.
// R4 - Divider control selects bank, oscillator stop on power failure, test or reset.
// R5 - Update pending is high 244 us before an update, low when frozen.
// R6 - Update follows a periodic tick by at least half period plus 244 us; here rate codes 3 to 5 (taps 1 to 3) fall short.
// R7 - Alarm flag rises 30.5 us after the update that matched the alarm.
// R8 - Reading the flag register clears all flags and the interrupt; so does reset.
// R9 - Daylight saving enable drives the spring jump and survives master reset.
// R10 - Daylight saving enable also drives the autumn step back.
// R11 - Mode bit 1 selects 12 or 24 hour format, unaffected by reset.
// R12 - Mode bit 2 selects BCD or binary format, unaffected by reset.
// R13 - Mode bit 3 always reads zero.
// R14 - Update, alarm and periodic enables are read/write and cleared by master reset.
// R15 - Update flag sets at every update; alarm flag after an update that matches.
// R16 - Freeze bit holds the user time copy; master reset leaves it alone.
// R17 - Flag register bits 3 to 0 read zero.
// R18 - Flags are read-only, cleared by master reset and by reading the register.
// R19 - Periodic flag sets on a transition of the selected divider tap.
// R20 - Flag bit 7 is the inverse of the active-low interrupt output.
// R21 - Validity register bits 6 to 0 read zero.
// R22 - Supply valid reads zero after a supply drop and is set by reading.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none

module rtcc_ctrl_regs
    import rtcc_pkg::*;
(
    input  wire logic       SYS_CLK,
    input  wire logic       SYS_RST,
    input  wire logic       PWRON_RST,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    output logic      [7:0] REG_RDATA,
    input  wire logic       OSC_32K,
    input  wire logic       SUPPLY_LOW,
    input  wire logic       ALARM_MATCH,
    output logic            IRQ_N,
    output logic            TIME_UPDATE,
    output logic            USER_COPY_FREEZE,
    output logic            DST_ENABLE,
    output logic            HOUR24_MODE,
    output logic            BINARY_FORMAT,
    output logic      [1:0] BANK_SEL,
    output logic            OSC_STOP_REQ,
    output logic            DIV_TEST_MODE
);

    // Tap of the divider chain for a rate code; bit 4 marks a valid tap
    function automatic logic [4:0] rtcc_tap(input logic [3:0] rs);
        logic [4:0] t;
        case (rs)
            4'h0:    t = 5'h00;
            4'h1:    t = 5'h16;
            4'h2:    t = 5'h17;
            default: t = {1'b1, 4'(rs - 4'h2)};
        endcase
        return t;
    endfunction : rtcc_tap

    function automatic rtcc_div_mode_t rtcc_div_mode(input logic [2:0] dv,
                                                     input logic       low);
        rtcc_div_mode_t m;
        case (dv)
            3'h0, 3'h1:   m = low ? RTCC_DIV_HALT : RTCC_DIV_RUN;
            RTCC_DV_TEST: m = RTCC_DIV_TEST;
            3'h6, 3'h7:   m = RTCC_DIV_RESET;
            default:      m = RTCC_DIV_RUN;
        endcase
        return m;
    endfunction : rtcc_div_mode

    rtcc_state_t    st_reg;
    rtcc_state_t    st_next;
    rtcc_div_mode_t div_mode;
    logic           low_s;
    logic           osc_tick;
    logic           counting;
    logic           upd_ev;
    logic           per_ev;
    logic           alm_ev;
    logic           update_pending;
    logic [4:0]     tap;
    logic           rd_flags;
    logic           rd_valid;
    logic           wr_ok;

    always_comb begin
        st_next = st_reg;
        st_next.sync_osc = {st_reg.sync_osc[1:0], OSC_32K};
        st_next.sync_low = {st_reg.sync_low[0], SUPPLY_LOW};
        low_s    = st_reg.sync_low[1];
        div_mode = rtcc_div_mode(st_reg.divider_bank_ctrl, low_s);                 // R4
        counting = (div_mode == RTCC_DIV_RUN) || (div_mode == RTCC_DIV_TEST);
        osc_tick = st_reg.sync_osc[1] && !st_reg.sync_osc[2] && counting;

        // Divider chain
        case (div_mode)
            RTCC_DIV_RESET: st_next.div_cnt = '0;                                 // R4
            RTCC_DIV_RUN,
            RTCC_DIV_TEST:  st_next.div_cnt = osc_tick ? st_reg.div_cnt + 15'h1
                                                       : st_reg.div_cnt;
            RTCC_DIV_HALT:  st_next.div_cnt = st_reg.div_cnt;
            default:        st_next.div_cnt = st_reg.div_cnt;
        endcase

        // Update lands UPDATE_PENDING lead ticks after the second boundary
        upd_ev = osc_tick && (st_next.div_cnt == RTCC_UPD_POS);                  // R6
        update_pending    = counting && (st_reg.div_cnt < RTCC_UPD_POS) && !st_reg.freeze;   // R5

        tap    = rtcc_tap(st_reg.tick_rate_select);                               // R2
        per_ev = tap[4] && st_next.div_cnt[tap[3:0]] && !st_reg.div_cnt[tap[3:0]]; // R19

        // Alarm fires a fixed number of ticks after the matching update
        alm_ev = osc_tick && (st_reg.alarm_delay == 2'h1);                        // R7
        if (osc_tick && (st_reg.alarm_delay != 2'h0)) begin
            st_next.alarm_delay = st_reg.alarm_delay - 2'h1;
        end
        if (upd_ev && ALARM_MATCH) begin
            st_next.alarm_delay = 2'(RTCC_ALARM_DELAY_TICKS);                     // R15
        end

        // Register access
        wr_ok    = REG_WR && st_reg.wr_unlock;                                    // R1
        rd_flags = REG_RD && (REG_ADDR == RTCC_OFS_FLAGS);
        rd_valid = REG_RD && (REG_ADDR == RTCC_OFS_VALIDITY);

        if (wr_ok && (REG_ADDR == RTCC_OFS_RATE_BANK)) begin
            st_next.tick_rate_select  = REG_WDATA[RTCC_RATE_LSB +: 4];            // R3
            st_next.divider_bank_ctrl = REG_WDATA[RTCC_BANK_LSB +: 3];            // R3
        end
        if (wr_ok && (REG_ADDR == RTCC_OFS_MODE)) begin
            st_next.dst_enable        = REG_WDATA[RTCC_DST_BIT];                  // R9
            st_next.hour24_sel        = REG_WDATA[RTCC_H24_BIT];                  // R11
            st_next.binary_format_sel = REG_WDATA[RTCC_BIN_BIT];                  // R12
            st_next.update_irq_en     = REG_WDATA[RTCC_UIE_BIT];                  // R14
            st_next.alarm_irq_en      = REG_WDATA[RTCC_AIE_BIT];                  // R14
            st_next.periodic_irq_en   = REG_WDATA[RTCC_PIE_BIT];                  // R14
            st_next.freeze            = REG_WDATA[RTCC_FREEZE_BIT];               // R16
        end

        st_next.rdata = 8'h00;
        if (REG_RD) begin
            case (REG_ADDR)
                RTCC_OFS_RATE_BANK: begin
                    st_next.rdata[RTCC_RATE_LSB +: 4] = st_reg.tick_rate_select;
                    st_next.rdata[RTCC_BANK_LSB +: 3] = st_reg.divider_bank_ctrl;
                    st_next.rdata[RTCC_UIP_BIT]       = update_pending;                      // R5
                end
                RTCC_OFS_MODE: begin
                    st_next.rdata[RTCC_DST_BIT]    = st_reg.dst_enable;
                    st_next.rdata[RTCC_H24_BIT]    = st_reg.hour24_sel;
                    st_next.rdata[RTCC_BIN_BIT]    = st_reg.binary_format_sel;
                    st_next.rdata[RTCC_UIE_BIT]    = st_reg.update_irq_en;
                    st_next.rdata[RTCC_AIE_BIT]    = st_reg.alarm_irq_en;
                    st_next.rdata[RTCC_PIE_BIT]    = st_reg.periodic_irq_en;
                    st_next.rdata[RTCC_FREEZE_BIT] = st_reg.freeze;               // R13
                end
                RTCC_OFS_FLAGS: begin
                    st_next.rdata[RTCC_UF_BIT]   = st_reg.update_done_flag;       // R17
                    st_next.rdata[RTCC_AF_BIT]   = st_reg.alarm_hit_flag;
                    st_next.rdata[RTCC_PF_BIT]   = st_reg.periodic_tick_flag;
                    st_next.rdata[RTCC_IRQ_PENDING_SUMMARY_BIT] = st_reg.irq;                    // R20
                end
                RTCC_OFS_VALIDITY: begin
                    st_next.rdata[RTCC_VALID_BIT] = st_reg.supply_valid;          // R21
                end
                default: st_next.rdata = 8'h00;
            endcase
        end

        // Flags: a read clears them, an event in the same cycle still sets
        if (rd_flags) begin
            st_next.update_done_flag   = 1'b0;                                    // R8
            st_next.alarm_hit_flag     = 1'b0;                                    // R18
            st_next.periodic_tick_flag = 1'b0;
        end
        if (upd_ev) begin
            st_next.update_done_flag = 1'b1;                                      // R15
        end
        if (alm_ev) begin
            st_next.alarm_hit_flag = 1'b1;                                        // R15
        end
        if (per_ev) begin
            st_next.periodic_tick_flag = 1'b1;                                    // R19
        end

        // Reading validity marks data valid and opens writes; a low supply wins over the valid bit, not the unlock
        if (rd_valid) begin
            st_next.supply_valid = 1'b1;                                          // R22
            st_next.wr_unlock    = 1'b1;                                          // R1
        end
        if (low_s) begin
            st_next.supply_valid = 1'b0;                                          // R22
        end

        st_next.upd_pulse = upd_ev;

        if (SYS_RST) begin
            st_next.update_irq_en      = 1'b0;                                    // R14
            st_next.alarm_irq_en       = 1'b0;
            st_next.periodic_irq_en    = 1'b0;
            st_next.update_done_flag   = 1'b0;                                    // R18
            st_next.alarm_hit_flag     = 1'b0;
            st_next.periodic_tick_flag = 1'b0;
            st_next.alarm_delay        = 2'h0;
            st_next.rdata              = 8'h00;
        end

        st_next.irq = (st_next.update_done_flag   && st_next.update_irq_en)
                   || (st_next.alarm_hit_flag     && st_next.alarm_irq_en)
                   || (st_next.periodic_tick_flag && st_next.periodic_irq_en);    // R20
    end

    always_ff @(posedge SYS_CLK) begin
        if (PWRON_RST) begin
            st_reg <= RTCC_POR_STATE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign REG_RDATA        = st_reg.rdata;
    assign IRQ_N            = !st_reg.irq;                                        // R20
    assign TIME_UPDATE      = st_reg.upd_pulse;
    assign USER_COPY_FREEZE = st_reg.freeze;                                      // R16
    assign DST_ENABLE       = st_reg.dst_enable;                                  // R10
    assign HOUR24_MODE      = st_reg.hour24_sel;                                  // R11
    assign BINARY_FORMAT    = st_reg.binary_format_sel;                           // R12
    assign BANK_SEL         = (st_reg.divider_bank_ctrl == RTCC_DV_BANK1) ? 2'h1 :
                              (st_reg.divider_bank_ctrl == RTCC_DV_BANK2) ? 2'h2 : 2'h0;
    assign OSC_STOP_REQ     = (div_mode == RTCC_DIV_HALT);                        // R4
    assign DIV_TEST_MODE    = (div_mode == RTCC_DIV_TEST);

    // Checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST || PWRON_RST);

    sequence s_flag_read;
        REG_RD && (REG_ADDR == RTCC_OFS_FLAGS);
    endsequence

    sequence s_quiet_events;
        !upd_ev && !alm_ev && !per_ev;
    endsequence

    chk_locked_write: assert property (                                           // R1
        (!st_reg.wr_unlock && REG_WR && !rd_valid) |=>
            ($stable(st_reg.tick_rate_select) && $stable(st_reg.freeze)
             && $stable(st_reg.dst_enable)))
        else $error("write took effect before validity read");

    chk_uip_frozen: assert property (                                             // R5
        (REG_RD && REG_ADDR == RTCC_OFS_RATE_BANK && st_reg.freeze)
            |=> !REG_RDATA[RTCC_UIP_BIT])
        else $error("update pending read high while frozen");

    chk_alarm_delay: assert property (                                            // R7
        (st_reg.alarm_delay == 2'h1 && osc_tick) |=> st_reg.alarm_hit_flag)
        else $error("alarm flag missing after delay");

    chk_flags_clear: assert property (                                            // R8
        (s_flag_read and s_quiet_events) |=>
            (!st_reg.update_done_flag && !st_reg.alarm_hit_flag
             && !st_reg.periodic_tick_flag && IRQ_N))
        else $error("flags not cleared by read");

    chk_irq_pending_summary_inverse: assert property (                                           // R20
        s_flag_read |=> (REG_RDATA[RTCC_IRQ_PENDING_SUMMARY_BIT] == !$past(IRQ_N)))
        else $error("summary bit does not mirror interrupt output");

    chk_reserved_zero: assert property (                                          // R17
        s_flag_read |=> (REG_RDATA[3:0] == 4'h0))
        else $error("flag reserved bits not zero");

    chk_valid_low_zero: assert property (                                         // R21
        (REG_RD && REG_ADDR == RTCC_OFS_VALIDITY) |=> (REG_RDATA[6:0] == 7'h00))
        else $error("validity reserved bits not zero");

    chk_valid_set_read: assert property (                                         // R22
        (rd_valid && !low_s) |=> st_reg.supply_valid)
        else $error("supply valid not set by read");

    chk_valid_old_value: assert property (                                        // R22
        rd_valid |=> (REG_RDATA[RTCC_VALID_BIT] == $past(st_reg.supply_valid)))
        else $error("validity read did not show the previous bit");

    chk_bit3_zero: assert property (                                              // R13
        (REG_RD && REG_ADDR == RTCC_OFS_MODE) |=> !REG_RDATA[3])
        else $error("unused mode bit read as one");

    chk_div_reset_hold: assert property (                                         // R4
        (div_mode == RTCC_DIV_RESET) |=> (st_reg.div_cnt == 15'h0))
        else $error("divider counter moved while held in reset");

    chk_irq_level: assert property (                                              // R20
        IRQ_N == !((st_reg.update_done_flag && st_reg.update_irq_en)
                   || (st_reg.alarm_hit_flag && st_reg.alarm_irq_en)
                   || (st_reg.periodic_tick_flag && st_reg.periodic_irq_en)))
        else $error("interrupt output does not match flags and enables");

    chk_uip_window: assert property (                                             // R5
        (REG_RD && REG_ADDR == RTCC_OFS_RATE_BANK && counting && !st_reg.freeze
         && st_reg.div_cnt < RTCC_UPD_POS) |=> REG_RDATA[RTCC_UIP_BIT])
        else $error("update pending low inside the update window");

    chk_periodic_set: assert property (                                           // R19
        per_ev |=> st_reg.periodic_tick_flag)
        else $error("periodic flag missed tap transition");

    chk_update_flag: assert property (                                            // R15
        upd_ev |=> (st_reg.update_done_flag && TIME_UPDATE))
        else $error("update flag or strobe missing");

    chk_enable_reset: assert property (                                           // R14
        @(posedge SYS_CLK) disable iff (PWRON_RST)
        SYS_RST |=> (!st_reg.update_irq_en && !st_reg.alarm_irq_en
                     && !st_reg.periodic_irq_en && IRQ_N))
        else $error("enables or interrupt survived master reset");

    chk_rate_keep: assert property (                                              // R3
        @(posedge SYS_CLK) disable iff (PWRON_RST)
        (SYS_RST && !REG_WR) |=> ($stable(st_reg.tick_rate_select)
                                  && $stable(st_reg.divider_bank_ctrl)))
        else $error("rate or divider field changed by master reset");

endmodule : rtcc_ctrl_regs

`default_nettype wire

// [dv/rtc_control_status_regs_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module rtc_control_status_regs_tb
    import rtcc_pkg::*;
;
    logic        sys_clk;
    logic        sys_rst;
    logic        pwron_rst;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        osc_32k = 1'b0;
    logic        supply_low;
    logic        alarm_match;
    logic        irq_n;
    logic        time_update;
    logic        user_copy_freeze;
    logic        dst_enable;
    logic        hour24_mode;
    logic        binary_format;
    logic [1:0]  bank_sel;
    logic        osc_stop_req;
    logic        div_test_mode;
    int          err_count;
    int          samples_checked;
    int          cyc = 0;
    int          osc_div = 0;
    int          seed;
    int          n;
    logic [7:0]  d;
    logic [7:0]  mode_m;
    logic [7:0]  rate_m;

    rtcc_ctrl_regs rtcc_ctrl_regs_i (
        .SYS_CLK          (sys_clk),
        .SYS_RST          (sys_rst),
        .PWRON_RST        (pwron_rst),
        .REG_ADDR         (reg_addr),
        .REG_WDATA        (reg_wdata),
        .REG_WR           (reg_wr),
        .REG_RD           (reg_rd),
        .REG_RDATA        (reg_rdata),
        .OSC_32K          (osc_32k),
        .SUPPLY_LOW       (supply_low),
        .ALARM_MATCH      (alarm_match),
        .IRQ_N            (irq_n),
        .TIME_UPDATE      (time_update),
        .USER_COPY_FREEZE (user_copy_freeze),
        .DST_ENABLE       (dst_enable),
        .HOUR24_MODE      (hour24_mode),
        .BINARY_FORMAT    (binary_format),
        .BANK_SEL         (bank_sel),
        .OSC_STOP_REQ     (osc_stop_req),
        .DIV_TEST_MODE    (div_test_mode)
    );

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Sped-up oscillator: one tick every 8 system clocks
    always @(posedge sys_clk) begin
        osc_div <= (osc_div == 3) ? 0 : osc_div + 1;
        if (osc_div == 3) begin
            osc_32k <= ~osc_32k;
        end
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        $display("Comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    task automatic wait_low_irq;
        n = 0;
        while (irq_n !== 1'b0 && n < 400) begin
            @(negedge sys_clk);
            n++;
        end
    endtask : wait_low_irq

    initial begin
        {sys_rst, pwron_rst} = 2'b11;
        {reg_wr, reg_rd, supply_low, alarm_match} = '0;
        {reg_addr, reg_wdata} = '0;
        {err_count, samples_checked} = '0;
        seed = 4;
        repeat (12) @(posedge sys_clk);
        {sys_rst, pwron_rst} <= 2'b00;

        wr(RTCC_OFS_MODE, 8'h12);
        rd(RTCC_OFS_MODE, d);      `CHK(d, 8'h00)
        rd(RTCC_OFS_VALIDITY, d);  `CHK(d, 8'h00)
        rd(RTCC_OFS_VALIDITY, d);  `CHK(d, 8'h80)
        rd(8'h33, d);              `CHK(d, 8'h00)
        $display("test lock done");

        for (int i = 0; i < 4; i++) begin
            mode_m = 8'($random(seed)) & 8'h77;
            wr(RTCC_OFS_MODE, mode_m | 8'h08);
            rd(RTCC_OFS_MODE, d);  `CHK(d, mode_m)
            `CHK({binary_format, hour24_mode, dst_enable}, mode_m[2:0])
        end
        $display("test mode done");

        wr(RTCC_OFS_MODE, 8'h30);
        wr(RTCC_OFS_RATE_BANK, 8'h60);
        alarm_match <= 1'b1;
        wr(RTCC_OFS_RATE_BANK, 8'h20);
        rd(RTCC_OFS_RATE_BANK, d); `CHK(d, 8'hA0)
        n = 0;
        while (time_update !== 1'b1 && n < 400) begin
            @(negedge sys_clk);
            n++;
        end
        `CHK(time_update, 1'b1)
        `CHK(irq_n, 1'b0)
        rd(RTCC_OFS_FLAGS, d);     `CHK(d, 8'h90)
        @(posedge sys_clk);
        alarm_match <= 1'b0;
        repeat (30) @(negedge sys_clk);
        `CHK(irq_n, 1'b0)
        rd(RTCC_OFS_FLAGS, d);     `CHK(d, 8'hA0)
        `CHK(irq_n, 1'b1)
        rd(RTCC_OFS_FLAGS, d);     `CHK(d, 8'h00)
        rd(RTCC_OFS_RATE_BANK, d); `CHK(d, 8'h20)
        $display("test update and alarm done");

        wr(RTCC_OFS_RATE_BANK, 8'h23);
        wr(RTCC_OFS_MODE, 8'h40);
        rd(RTCC_OFS_FLAGS, d);
        wait_low_irq();
        `CHK(irq_n, 1'b0)
        rd(RTCC_OFS_FLAGS, d);     `CHK(d, 8'hC0)
        wr(RTCC_OFS_MODE, 8'h00);
        repeat (2) @(negedge sys_clk);
        `CHK(irq_n, 1'b1)
        rd(RTCC_OFS_FLAGS, d);     `CHK(d & 8'h8F, 8'h00)
        wr(RTCC_OFS_RATE_BANK, 8'h20);
        rd(RTCC_OFS_FLAGS, d);
        repeat (100) @(negedge sys_clk);
        rd(RTCC_OFS_FLAGS, d);     `CHK(d, 8'h00)
        $display("test periodic done");

        @(posedge sys_clk);
        supply_low <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            wr(RTCC_OFS_RATE_BANK, {1'b0, 3'(c), 4'h0});
            repeat (4) @(negedge sys_clk);
            `CHK(bank_sel, (c >= 2 && c <= 4) ? 2'(c - 2) : 2'd0)
            `CHK(div_test_mode, 1'(c == 5))
            `CHK(osc_stop_req, 1'(c < 2))
        end
        @(posedge sys_clk);
        supply_low <= 1'b0;
        repeat (4) @(negedge sys_clk);
        rd(RTCC_OFS_VALIDITY, d);  `CHK(d, 8'h00)
        rd(RTCC_OFS_VALIDITY, d);  `CHK(d, 8'h80)
        $display("test bank and supply done");

        // Slow taps only, so no periodic flag can rise before the flag read
        rate_m = {1'b0, 3'h3, 1'b1, 3'($random(seed))};
        wr(RTCC_OFS_RATE_BANK, rate_m);
        wr(RTCC_OFS_MODE, 8'hF7);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(RTCC_OFS_MODE, d);      `CHK(d, 8'h87)
        rd(RTCC_OFS_RATE_BANK, d); `CHK(d & 8'h7F, rate_m)
        `CHK({user_copy_freeze, binary_format, hour24_mode, dst_enable}, 4'hF)
        `CHK(bank_sel, 2'd1)
        rd(RTCC_OFS_FLAGS, d);     `CHK(d, 8'h00)
        $display("test master reset done");
        report_and_stop();
    end
endmodule : rtc_control_status_regs_tb
`default_nettype wire
